// [hw/sdt_pkg.sv]
package sdt_pkg;
    // bus geometry
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;

    // number of trigger contributors feeding the or-trees
    localparam int N_SOC_ANALYZERS = 4;
    localparam int N_ELEMENTS = 4;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_CTRL = 12'h000;
    localparam logic [ADDR_W-1:0] OFS_INT_STAT = 12'h004;
    localparam logic [ADDR_W-1:0] OFS_INT_MASK = 12'h008;

    // scan_debug_control field positions
    localparam int BIT_MASTER_EN = 0;
    localparam int BIT_SUBSYS_INC = 1;
    localparam int BIT_C0_INC = 2;
    localparam int BIT_C1_INC = 3;
    localparam int BIT_CL_STOP = 4;
    localparam int BIT_SOC_STOP = 5;
    localparam int BIT_SOFT_INC = 6;
    localparam int BIT_SOFT_FIRE = 7;
    localparam int BIT_MODE = 8;
    localparam int BIT_OUT0 = 9;
    localparam int RSV_LSB = 10;
    localparam int RSV_W = 6;
    localparam int WAIT_LSB = 16;
    localparam int WAIT_W = 16;

    // interrupt status / mask layout
    localparam int IRQ_W = 2;
    localparam int IRQ_DUMP = 0;
    localparam int IRQ_SOFT = 1;

    // reset values
    localparam logic [WAIT_W-1:0] WAIT_RST = 16'h0000;
    localparam logic [IRQ_W-1:0] IRQ_RST = 2'h0;
    localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;

    // manual trigger delay sequencer states
    typedef enum logic {DLY_IDLE, DLY_COUNT} sdt_dly_state_t;

    // true when the bus address selects the given register word
    function automatic logic sdt_hit(logic [ADDR_W-1:0] addr, logic [ADDR_W-1:0] ofs);
        return addr == ofs;
    endfunction : sdt_hit
endpackage : sdt_pkg

// [hw/sdt_delay_if.sv]
interface sdt_delay_if;
    import sdt_pkg::*;
    logic start;
    logic [WAIT_W-1:0] wait_count;
    logic busy;
    logic done;

    modport ctl (output start, output wait_count, input busy, input done);
    modport tmr (input start, input wait_count, output busy, output done);
endinterface : sdt_delay_if

// [hw/sdt_delay.sv]
module sdt_delay (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic ref_tick,
    sdt_delay_if.tmr dly
);
    import sdt_pkg::*;

    sdt_dly_state_t state_ff;
    logic [WAIT_W-1:0] cnt_ff;
    logic done_ff;

    // load on start, count reference ticks, pulse done when the count is spent
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_ff <= DLY_IDLE;
            cnt_ff <= WAIT_RST;
            done_ff <= 1'b0;
        end else if (ce) begin
            done_ff <= 1'b0;
            unique case (state_ff)
                DLY_IDLE: begin
                    if (dly.start) begin
                        cnt_ff <= dly.wait_count;
                        state_ff <= DLY_COUNT;
                    end
                end
                DLY_COUNT: begin
                    if (cnt_ff == WAIT_RST) begin
                        done_ff <= 1'b1;
                        state_ff <= DLY_IDLE;
                    end else if (ref_tick) begin
                        cnt_ff <= cnt_ff - 16'h0001;
                    end
                end
            endcase
        end
    end

    assign dly.busy = (state_ff == DLY_COUNT);
    assign dly.done = done_ff;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    // a pending count only moves on a reference tick
    a_wait_hold: assert property (
        ce && state_ff == DLY_COUNT && cnt_ff != WAIT_RST
        |=> cnt_ff == $past(cnt_ff) - {15'h0000, $past(ref_tick)})
        else $error("delay count moved without a reference tick");
endmodule : sdt_delay

// [hw/sdt_trigger_ctrl.sv]
// Summary of operation
// - sixteen-bit reference-tick delay before manual dump
// - status bits nine, eight, five, four ignore writes
// - bit nine shows or of analyzer outputs
// - bit eight sticky once debug mode entered
// - writing one fires dump only when included
// - bit six includes software trigger as source
// - bit five shows or of soc stop triggers
// - bit four shows or of cluster stops
// - bit three includes cluster one halt event
// - bit two includes cluster zero halt event
// - bit one includes subsystem reset requests
// - no debug mode while master enable clear
// - bits fifteen to ten read zero
//
// Decided for this implementation: register access over APB and the address map.
module sdt_trigger_ctrl (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic CE,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [sdt_pkg::ADDR_W-1:0] PADDR,
    input wire logic [sdt_pkg::DATA_W-1:0] PWDATA,
    output logic [sdt_pkg::DATA_W-1:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic [sdt_pkg::N_SOC_ANALYZERS-1:0] ANALYZER_OUT0,
    input wire logic [sdt_pkg::N_SOC_ANALYZERS-1:0] SOC_ANALYZER_STOP,
    input wire logic CLUSTER0_ANALYZER_STOP,
    input wire logic CLUSTER1_ANALYZER_STOP,
    input wire logic [sdt_pkg::N_ELEMENTS-1:0] CLUSTER0_HALT,
    input wire logic [sdt_pkg::N_ELEMENTS-1:0] CLUSTER1_HALT,
    input wire logic MGMT_RESET_REQ,
    input wire logic SYSCTL_RESET_REQ,
    input wire logic REF_TICK,
    output logic SCAN_DUMP_START,
    output logic SCAN_DEBUG_MODE,
    output logic IRQ
);
    import sdt_pkg::*;

    // control fields written by software
    logic en_ff;
    logic subsys_inc_ff;
    logic c0_inc_ff;
    logic c1_inc_ff;
    logic soft_inc_ff;
    logic [WAIT_W-1:0] wait_ff;

    // observed state
    logic out0_ff;
    logic soc_stop_ff;
    logic cl_stop_ff;
    logic mode_ff;
    logic start_ff;

    // bus answer and interrupt state
    logic pready_ff;
    logic pslverr_ff;
    logic [DATA_W-1:0] prdata_ff;
    logic [IRQ_W-1:0] stat_ff;
    logic [IRQ_W-1:0] mask_ff;
    logic irq_ff;

    logic acc;
    logic commit;
    logic wr;
    logic hit_ctrl;
    logic hit_stat;
    logic hit_mask;
    logic mapped;
    logic soc_out0_any;
    logic soc_stop_any;
    logic cl_stop_any;
    logic c0_halt_any;
    logic c1_halt_any;
    logic subsys_req_any;
    logic soft_src;
    logic any_src;
    logic nxt_start;
    logic [DATA_W-1:0] ctrl_view;
    logic [DATA_W-1:0] nxt_rdata;
    logic [IRQ_W-1:0] ev;
    logic irq_any;

    sdt_delay_if dly_if ();

    sdt_delay u_delay (
        .clk (CLK),
        .rst_b (RST_B),
        .ce (CE),
        .ref_tick (REF_TICK),
        .dly (dly_if.tmr)
    );

    // one wait state: pready rises in the second access cycle, and the
    // transfer commits at the edge that samples it high
    assign acc = PSEL & PENABLE;
    assign commit = acc & pready_ff;
    assign wr = commit & PWRITE;
    assign hit_ctrl = sdt_hit(PADDR, OFS_CTRL);
    assign hit_stat = sdt_hit(PADDR, OFS_INT_STAT);
    assign hit_mask = sdt_hit(PADDR, OFS_INT_MASK);
    assign mapped = hit_ctrl | hit_stat | hit_mask;

    // trigger or-trees
    assign soc_out0_any = |ANALYZER_OUT0;
    assign soc_stop_any = |SOC_ANALYZER_STOP;
    assign cl_stop_any = CLUSTER0_ANALYZER_STOP | CLUSTER1_ANALYZER_STOP;
    assign c0_halt_any = |CLUSTER0_HALT;
    assign c1_halt_any = |CLUSTER1_HALT;
    assign subsys_req_any = MGMT_RESET_REQ | SYSCTL_RESET_REQ;

    // a manual fire is accepted only with inclusion set in the same write;
    // a second fire while one is counting is dropped rather than restarting
    assign dly_if.start = wr & hit_ctrl & PWDATA[BIT_SOFT_FIRE]
        & PWDATA[BIT_SOFT_INC] & ~dly_if.busy;
    assign dly_if.wait_count = PWDATA[WAIT_LSB +: WAIT_W];

    // gather every included source into one decision
    assign soft_src = dly_if.done & soft_inc_ff;
    assign any_src = soc_stop_ff | cl_stop_ff
        | (c0_inc_ff & c0_halt_any)
        | (c1_inc_ff & c1_halt_any)
        | (subsys_inc_ff & subsys_req_any)
        | soft_src;
    assign nxt_start = en_ff & any_src & ~mode_ff;

    // control register; read-only fields are not written here
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            en_ff <= 1'b0;
            subsys_inc_ff <= 1'b0;
            c0_inc_ff <= 1'b0;
            c1_inc_ff <= 1'b0;
            soft_inc_ff <= 1'b0;
            wait_ff <= WAIT_RST;
        end else if (CE && wr && hit_ctrl) begin
            en_ff <= PWDATA[BIT_MASTER_EN];
            subsys_inc_ff <= PWDATA[BIT_SUBSYS_INC];
            c0_inc_ff <= PWDATA[BIT_C0_INC];
            c1_inc_ff <= PWDATA[BIT_C1_INC];
            soft_inc_ff <= PWDATA[BIT_SOFT_INC];
            wait_ff <= PWDATA[WAIT_LSB +: WAIT_W];
        end
    end

    // registered source views, one cycle behind the pins
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            out0_ff <= 1'b0;
            soc_stop_ff <= 1'b0;
            cl_stop_ff <= 1'b0;
        end else if (CE) begin
            out0_ff <= soc_out0_any;
            soc_stop_ff <= soc_stop_any;
            cl_stop_ff <= cl_stop_any;
        end
    end

    // dump start pulse and sticky mode; only reset leaves debug mode
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            start_ff <= 1'b0;
            mode_ff <= 1'b0;
        end else if (CE) begin
            start_ff <= nxt_start;
            mode_ff <= mode_ff | nxt_start;
        end
    end

    // interrupt events: set wins over a same-cycle write-one clear
    assign ev[IRQ_DUMP] = nxt_start;
    assign ev[IRQ_SOFT] = dly_if.done;
    // any unmasked status bit; the output flop adds one cycle of lag
    assign irq_any = |(stat_ff & mask_ff);

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            stat_ff <= IRQ_RST;
            mask_ff <= IRQ_RST;
            irq_ff <= 1'b0;
        end else if (CE) begin
            if (wr && hit_stat) begin
                stat_ff <= (stat_ff & ~PWDATA[IRQ_W-1:0]) | ev;
            end else begin
                stat_ff <= stat_ff | ev;
            end
            if (wr && hit_mask) begin
                mask_ff <= PWDATA[IRQ_W-1:0];
            end
            irq_ff <= irq_any;
        end
    end

    // read view of the control register; bit seven reads a pending fire
    always_comb begin
        ctrl_view = RDATA_RST;
        ctrl_view[WAIT_LSB +: WAIT_W] = wait_ff;
        ctrl_view[BIT_OUT0] = out0_ff;
        ctrl_view[BIT_MODE] = mode_ff;
        ctrl_view[BIT_SOFT_FIRE] = dly_if.busy;
        ctrl_view[BIT_SOFT_INC] = soft_inc_ff;
        ctrl_view[BIT_SOC_STOP] = soc_stop_ff;
        ctrl_view[BIT_CL_STOP] = cl_stop_ff;
        ctrl_view[BIT_C1_INC] = c1_inc_ff;
        ctrl_view[BIT_C0_INC] = c0_inc_ff;
        ctrl_view[BIT_SUBSYS_INC] = subsys_inc_ff;
        ctrl_view[BIT_MASTER_EN] = en_ff;
    end

    // read mux; reserved bits stay at the zero default
    always_comb begin
        nxt_rdata = RDATA_RST;
        if (hit_ctrl) begin
            nxt_rdata = ctrl_view;
        end else if (hit_stat) begin
            nxt_rdata[IRQ_W-1:0] = stat_ff;
        end else if (hit_mask) begin
            nxt_rdata[IRQ_W-1:0] = mask_ff;
        end
    end

    // bus answer: ready pulses one cycle per transfer, error on unmapped
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= RDATA_RST;
        end else if (CE) begin
            pready_ff <= acc & ~pready_ff;
            pslverr_ff <= acc & ~pready_ff & ~mapped;
            if (acc && !pready_ff && !PWRITE) begin
                prdata_ff <= nxt_rdata;
            end
        end
    end

    assign PREADY = pready_ff;
    assign PSLVERR = pslverr_ff;
    assign PRDATA = prdata_ff;
    assign SCAN_DUMP_START = start_ff;
    assign SCAN_DEBUG_MODE = mode_ff;
    assign IRQ = irq_ff;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);

    // an accepted manual fire
    sequence s_fire_wr;
        CE && wr && hit_ctrl && PWDATA[BIT_SOFT_FIRE] && PWDATA[BIT_SOFT_INC]
            && !dly_if.busy;
    endsequence

    // the same write carries a zero wait
    sequence s_zero_wait;
        PWDATA[WAIT_LSB +: WAIT_W] == WAIT_RST;
    endsequence

    // an included source with master enable set starts the dump next cycle
    property p_src(logic inc, logic src);
        CE && en_ff && inc && src && !mode_ff |=> SCAN_DUMP_START && mode_ff;
    endproperty

    a_soft_zero_wait: assert property (
        s_fire_wr ##0 s_zero_wait ##1 CE |=> dly_if.done)
        else $error("manual fire with zero wait did not expire");
    a_soft_needs_incl: assert property (
        CE && wr && hit_ctrl && PWDATA[BIT_SOFT_FIRE] && !PWDATA[BIT_SOFT_INC]
            && !dly_if.busy |=> !dly_if.busy)
        else $error("manual fire accepted without inclusion");
    a_soft_dump: assert property (p_src(soft_inc_ff, dly_if.done))
        else $error("expired manual trigger did not start the dump");
    a_c1_halt: assert property (p_src(c1_inc_ff, c1_halt_any))
        else $error("cluster one halt did not start the dump");
    a_c0_halt: assert property (p_src(c0_inc_ff, c0_halt_any))
        else $error("cluster zero halt did not start the dump");
    a_subsys_req: assert property (p_src(subsys_inc_ff, subsys_req_any))
        else $error("subsystem reset request did not start the dump");
    a_master_gate: assert property (
        CE && !en_ff && !mode_ff |=> !mode_ff && !SCAN_DUMP_START)
        else $error("debug mode entered with master enable clear");
    a_mode_sticky: assert property (mode_ff |=> mode_ff)
        else $error("debug mode flag fell without reset");
    a_ro_ignore: assert property (
        CE && wr && hit_ctrl |=> ctrl_view[BIT_OUT0] == $past(soc_out0_any)
            && ctrl_view[BIT_SOC_STOP] == $past(soc_stop_any)
            && ctrl_view[BIT_CL_STOP] == $past(cl_stop_any)
            && mode_ff == ($past(mode_ff) || $past(nxt_start)))
        else $error("read-only field followed write data");
    a_reserved_zero: assert property (
        pready_ff && hit_ctrl |-> PRDATA[RSV_LSB +: RSV_W] == 6'h00)
        else $error("reserved field read nonzero");
    a_irq_level: assert property (CE |=> IRQ == $past(irq_any))
        else $error("interrupt output disagrees with status and mask");
endmodule : sdt_trigger_ctrl

// [dv/sdt_source_model.sv]
module sdt_source_model #(
    parameter int TICK_DIV = 5
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [19:0] src,
    output logic [3:0] out0,
    output logic [3:0] soc_stop,
    output logic c0_stop,
    output logic c1_stop,
    output logic [3:0] c0_halt,
    output logic [3:0] c1_halt,
    output logic mgmt_req,
    output logic sysctl_req,
    output logic ref_tick
);
    timeunit 1ns;
    timeprecision 1ps;
    int div_ff;

    // trigger levels move just after an edge, as on-chip sources do
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            {out0, soc_stop, c0_stop, c1_stop, c0_halt, c1_halt, mgmt_req, sysctl_req} <= '0;
        end else begin
            {out0, soc_stop, c0_stop, c1_stop, c0_halt, c1_halt, mgmt_req, sysctl_req} <= src;
        end
    end

    // reference clock seen as one-cycle ticks; slower than the bus clock
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            div_ff <= 0;
            ref_tick <= 1'b0;
        end else begin
            div_ff <= (div_ff == TICK_DIV - 1) ? 0 : div_ff + 1;
            ref_tick <= (div_ff == TICK_DIV - 1);
        end
    end
endmodule : sdt_source_model

// [dv/sdt_trigger_ctrl_test.sv]
module sdt_trigger_ctrl_test;
    timeunit 1ns;
    timeprecision 1ps;
    import sdt_pkg::*;
    logic clk, rst_b, psel, penable, pwrite, pready, pslverr, err, fire;
    logic ce;
    logic c0_stop, c1_stop, mgmt_req, sysctl_req, ref_tick, dump_start, dbg_mode, irq;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata, rd, wv;
    logic [3:0] out0, soc_stop, c0_halt, c1_halt;
    logic [19:0] src;
    int mismatches, tests_run, seed, starts, ticks, cyc, s0, t0, c0, n;

    sdt_source_model src_m (.clk(clk), .rst_b(rst_b), .src(src), .out0(out0),
        .soc_stop(soc_stop), .c0_stop(c0_stop), .c1_stop(c1_stop), .c0_halt(c0_halt),
        .c1_halt(c1_halt), .mgmt_req(mgmt_req), .sysctl_req(sysctl_req), .ref_tick(ref_tick));
    sdt_trigger_ctrl uut (.CLK(clk), .RST_B(rst_b), .CE(ce), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .ANALYZER_OUT0(out0), .SOC_ANALYZER_STOP(soc_stop),
        .CLUSTER0_ANALYZER_STOP(c0_stop), .CLUSTER1_ANALYZER_STOP(c1_stop),
        .CLUSTER0_HALT(c0_halt), .CLUSTER1_HALT(c1_halt), .MGMT_RESET_REQ(mgmt_req),
        .SYSCTL_RESET_REQ(sysctl_req), .REF_TICK(ref_tick), .SCAN_DUMP_START(dump_start),
        .SCAN_DEBUG_MODE(dbg_mode), .IRQ(irq));

    // 125 MHz bus clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // tallies move after the edge, so tasks always read pre-edge counts
    always @(posedge clk) begin
        cyc <= cyc + 1;
        starts <= starts + (dump_start === 1'b1);
        ticks <= ticks + (ref_tick === 1'b1);
    end

    task automatic chk_word(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_word

    task automatic chk_bit(input logic got, input logic exp);
        chk_word(DATA_W'(got), DATA_W'(exp));
    endtask : chk_bit

    // one transfer; held until pready is seen, commit edge snapshots kept
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // no local limit: only the watchdog ends a wait for the answer
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        t0 = ticks;
        c0 = cyc;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    // sources drop with reset, since the dump can start only once per reset
    task automatic do_reset;
        rst_b <= 1'b0;
        src <= '0;
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
    endtask : do_reset

    task automatic wait_start(input int lim);
        int w;
        w = 0;
        while (dump_start !== 1'b1 && w < lim) begin
            @(posedge clk);
            w++;
        end
    endtask : wait_start

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : report_and_stop

    // control readback: writable fields kept, fire reads low, status from pins
    function automatic logic [DATA_W-1:0] ctrl_exp(input logic [DATA_W-1:0] w,
                                                   input logic [3:0] ro);
        return {w[31:16], 6'h00, ro[3:2], 1'b0, w[6], ro[1:0], w[3:0]};
    endfunction : ctrl_exp

    // source pattern k: c0 halt, c1 halt, mgmt, sysctl, soc stop, cluster stop
    function automatic logic [19:0] src_for(input int k, input int r);
        case (k)
            0: return 20'h0_0040 << r;
            1: return 20'h0_0004 << r;
            2: return 20'h0_0002;
            3: return 20'h0_0001;
            4: return 20'h0_1000 << r;
            default: return 20'h0_0400 << r[0];
        endcase
    endfunction : src_for

    function automatic logic [DATA_W-1:0] inc_bit(input int k);
        return (k == 0) ? 32'h0000_0004 : (k == 1) ? 32'h0000_0008 : 32'h0000_0002;
    endfunction : inc_bit

    // a hang counts as a failure
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        report_and_stop();
    end

    initial begin
        seed = 32'hbcbc_223b;
        rst_b = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        src = '0;
        ce = 1'b1;
        do_reset();
        // reset values, then an unmapped word is refused
        apb(1'b0, OFS_CTRL, '0);
        chk_word(rd, 32'h0000_0000);
        apb(1'b0, OFS_INT_MASK, '0);
        chk_word(rd, 32'h0000_0000);
        apb(1'b0, 12'h00C, '0);
        chk_bit(err, 1'b1);
        chk_word(rd, 32'h0000_0000);
        // writable fields hold, status and reserved bits ignore writes
        for (int i = 0; i < 5; i++) begin
            wv = (i == 0) ? 32'hFFFF_FF7E : $random(seed) & 32'hFFFF_FF7E;
            apb(1'b1, OFS_CTRL, wv);
            apb(1'b0, OFS_CTRL, '0);
            chk_word(rd, ctrl_exp(wv, 4'h0));
        end
        // status bits follow the pins; master enable clear blocks any dump
        s0 = starts;
        for (int i = 0; i < 3; i++) begin
            src <= (i == 2) ? 20'hF_FFFF : 20'($random(seed));
            repeat (4) @(posedge clk);
            apb(1'b0, OFS_CTRL, '0);
            chk_word(rd, ctrl_exp(wv, {|src[19:16], 1'b0, |src[15:12], |src[11:10]}));
        end
        chk_word(DATA_W'(starts - s0), 32'h0000_0000);
        chk_bit(dbg_mode, 1'b0);
        // each hardware source with and without its include bit; the soc and cluster stops have none and fire either way
        for (int k = 0; k < 6; k++) begin
            for (int inc = 0; inc < 2; inc++) begin
                do_reset();
                apb(1'b1, OFS_INT_MASK, 32'h0000_0001);
                apb(1'b1, OFS_CTRL, 32'h0000_0001 | (inc != 0 ? inc_bit(k) : 32'h0000_0000));
                s0 = starts;
                src <= src_for(k, $random(seed) & 3);
                // a frozen block must not react to a live source
                if (k == 1 && inc == 1) begin
                    ce <= 1'b0;
                    repeat (6) @(posedge clk);
                    chk_word(DATA_W'(starts - s0), 32'h0000_0000);
                    ce <= 1'b1;
                end
                wait_start(10);
                repeat (8) @(posedge clk);
                fire = (inc != 0) || (k > 3);
                chk_word(DATA_W'(starts - s0), DATA_W'(fire));
                chk_bit(dbg_mode, fire);
                chk_bit(irq, fire);
                apb(1'b0, OFS_CTRL, '0);
                chk_bit(rd[BIT_MODE], fire);
                apb(1'b1, OFS_INT_STAT, 32'h0000_0001);
                apb(1'b0, OFS_INT_STAT, '0);
                chk_word(rd, 32'h0000_0000);
                chk_bit(irq, 1'b0);
            end
        end
        // soft trigger: zero and random wait, include clear, master enable clear
        for (int m = 0; m < 4; m++) begin
            do_reset();
            apb(1'b1, OFS_INT_MASK, 32'h0000_0003);
            n = (m == 1 || m == 3) ? 2 + ($random(seed) & 3) : 0;
            wv = {16'(n), 8'h00, 1'b1, m != 2, 5'h00, m != 3};
            s0 = starts;
            apb(1'b1, OFS_CTRL, wv);
            // a fire still counting reads back as pending
            if (m == 3) begin
                apb(1'b0, OFS_CTRL, '0);
                chk_bit(rd[BIT_SOFT_FIRE], 1'b1);
            end
            wait_start(30 + 6 * n);
            if (m == 0) chk_word(DATA_W'(cyc - c0), 32'h0000_0003);
            if (m == 1) chk_bit((ticks - t0) inside {[n:n + 2]}, 1'b1);
            repeat (4) @(posedge clk);
            fire = (m < 2);
            chk_word(DATA_W'(starts - s0), DATA_W'(fire));
            apb(1'b0, OFS_CTRL, '0);
            chk_bit(rd[BIT_SOFT_FIRE], 1'b0);
            chk_bit(rd[BIT_MODE], fire);
            if (m != 2) begin
                apb(1'b0, OFS_INT_STAT, '0);
                chk_word(rd, {30'h0000_0000, 1'b1, fire});
                chk_bit(irq, 1'b1);
                apb(1'b1, OFS_INT_MASK, '0);
                apb(1'b0, OFS_INT_MASK, '0);
                chk_word(rd, 32'h0000_0000);
                chk_bit(irq, 1'b0);
            end
        end
        report_and_stop();
    end
endmodule : sdt_trigger_ctrl_test
